// File: core/tmpe_defines.vh
`ifndef TMPE_DEFINES_VH
`define TMPE_DEFINES_VH

// ==========================================================
// channel count and channel register pages
// ==========================================================
`define TMPE_NCH            12
`define TMPE_CTRL_LOW       4'h4
`define TMPE_PAGE_LO_MAX    4'h5
`define TMPE_PAGE_HI_MIN    4'h8
`define TMPE_PAGE_HI_MAX    4'hD
`define TMPE_PAGE_HI_GAP    4'h2

// ==========================================================
// transmit control register fields and reset values
// ==========================================================
`define TMPE_BIT_MON_SEL    5
`define TMPE_BIT_ERR_INS    4
`define TMPE_CTRL_RST       12'h000

// ==========================================================
// interrupt and alarm registers
// ==========================================================
`define TMPE_ADR_IRQ_STAT   8'hF0
`define TMPE_ADR_IRQ_MASK   8'hF4
`define TMPE_ADR_ALARM      8'hF8
`define TMPE_MASK_RST       12'h000

// ==========================================================
// drive monitor timing, in transmit bit periods
// ==========================================================
`define TMPE_DMO_PERIODS    8'h80

`endif

// File: core/tmpe_drive_mon.v
`timescale 1ns/100ps
`default_nettype none

module tmpe_drive_mon (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_i,
    // control
    input  wire       int_sel_i,
    input  wire       bit_en_i,
    // line pads and external monitor pins
    input  wire       pad_p_i,
    input  wire       pad_n_i,
    input  wire       mon_p_i,
    input  wire       mon_n_i,
    // alarm
    output reg        alarm_o
);

`include "tmpe_defines.vh"

// ==========================================================
// three-stage synchronisers with agreement filter
// ==========================================================
reg  [3:0] sa_r;
reg  [3:0] sb_r;
reg  [3:0] sc_r;
reg  [3:0] filt_r;
reg        seen_r;
reg  [7:0] cnt_r;
wire       pulse;
wire       active;

always @(posedge clk_i) begin
    if (rst_i) begin
        sa_r   <= 4'h0;
        sb_r   <= 4'h0;
        sc_r   <= 4'h0;
        filt_r <= 4'h0;
    end else begin
        sa_r   <= {mon_n_i, mon_p_i, pad_n_i, pad_p_i};
        sb_r   <= sa_r;
        sc_r   <= sb_r;
        // a level change is accepted only when stages two and three agree
        filt_r <= (sb_r & sc_r) | (filt_r & (sb_r | sc_r));
    end
end

// ==========================================================
// bipolar activity and empty-period count
// ==========================================================
assign pulse  = int_sel_i ? (filt_r[0] | filt_r[1])
                          : (filt_r[2] | filt_r[3]);
assign active = seen_r | pulse;

always @(posedge clk_i) begin
    if (rst_i) begin
        seen_r  <= 1'b0;
        cnt_r   <= 8'h00;
        alarm_o <= 1'b0;
    end else if (bit_en_i) begin
        seen_r <= 1'b0;
        if (active) begin
            cnt_r   <= 8'h00;
            alarm_o <= 1'b0;
        end else if (cnt_r != `TMPE_DMO_PERIODS) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == `TMPE_DMO_PERIODS - 8'h01)
                alarm_o <= 1'b1;
        end
    end else begin
        seen_r <= active;
    end
end

endmodule // tmpe_drive_mon

`default_nettype wire

// File: core/tmpe_tx_ctrl.v
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module tmpe_tx_ctrl (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // line output pads and external monitor pins, one bit per channel
    input  wire [11:0] line_out_positive_pad_i,
    input  wire [11:0] line_out_negative_pad_i,
    input  wire [11:0] monitor_in_positive_i,
    input  wire [11:0] monitor_in_negative_i,
    // transmit bit-period enables, one-cycle pulses on clk_i
    input  wire [11:0] tx_bit_en_i,
    // prbs enables from the prbs generator and receiver
    input  wire [11:0] prbs_gen_en_i,
    input  wire [11:0] prbs_rx_en_i,
    // results
    output wire [11:0] drive_monitor_alarm_o,
    output reg  [11:0] prbs_err_insert_o,
    output reg  [11:0] monitor_internal_o,
    output reg         irq_o
);

`include "tmpe_defines.vh"

// ==========================================================
// state
// ==========================================================
reg  [11:0] err_ins_r;
reg  [11:0] err_ins_prev_r;
reg  [11:0] alarm_prev_r;
reg  [11:0] irq_stat_r;
reg  [11:0] irq_mask_r;
reg  [11:0] irq_stat_nxt;
reg  [31:0] rd_nxt;
reg         ch_hit;
reg  [3:0]  ch_idx;
wire [11:0] alarm_w;
wire [11:0] alarm_rise;
wire [3:0]  page;
wire        acc;
wire        wr;
wire        rd;

// ==========================================================
// bus decode
// ==========================================================
// one access per request: ack is high for one cycle, then the
// request must drop, so acc never fires twice for one transfer
// only byte lane 0 reaches a control register and lanes 0-1 the
// interrupt mask; the upper data bits and sel[3:2] are not wired
// to any storage, so wider writes are harmless
assign acc  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr   = acc & wb_we_i;
assign rd   = acc & ~wb_we_i;
assign page = wb_adr_i[7:4];

// channel pages 0-5 map to channels 0-5, pages 8-D to channels 6-11
always @* begin
    ch_hit = 1'b0;
    ch_idx = 4'h0;
    if (wb_adr_i[3:0] == `TMPE_CTRL_LOW) begin
        if (page <= `TMPE_PAGE_LO_MAX) begin
            ch_hit = 1'b1;
            ch_idx = page;
        end else if (page >= `TMPE_PAGE_HI_MIN && page <= `TMPE_PAGE_HI_MAX) begin
            ch_hit = 1'b1;
            ch_idx = page - `TMPE_PAGE_HI_GAP;
        end
    end
end

// ==========================================================
// read mux
// ==========================================================
always @* begin
    rd_nxt = 32'h0000_0000;
    if (ch_hit) begin
        // only the monitor select and insert bits live here; the
        // reserved bits and the low bits read as zero
        rd_nxt[`TMPE_BIT_MON_SEL] = monitor_internal_o[ch_idx];
        rd_nxt[`TMPE_BIT_ERR_INS] = err_ins_r[ch_idx];
    end else begin
        case (wb_adr_i)
            `TMPE_ADR_IRQ_STAT: rd_nxt[11:0] = irq_stat_r;
            `TMPE_ADR_IRQ_MASK: rd_nxt[11:0] = irq_mask_r;
            `TMPE_ADR_ALARM:    rd_nxt[11:0] = alarm_w;
            default:            rd_nxt       = 32'h0000_0000;
        endcase
    end
end

// ==========================================================
// bus answer
// ==========================================================
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end else begin
        // unmapped addresses are acknowledged with zero data
        wb_ack_o <= acc;
        if (rd)
            wb_dat_o <= rd_nxt;
        else
            wb_dat_o <= 32'h0000_0000;
    end
end

// ==========================================================
// transmit control registers
// ==========================================================
// a write with sel[0] low leaves the channel untouched; the low
// bits 2..0 belong to another block and are neither stored nor
// driven here
always @(posedge clk_i) begin
    if (rst_i) begin
        monitor_internal_o <= `TMPE_CTRL_RST;
        err_ins_r          <= `TMPE_CTRL_RST;
    end else if (wr && ch_hit && wb_sel_i[0]) begin
        // writes to bits 7, 6, 3 are dropped
        monitor_internal_o[ch_idx] <= wb_dat_i[`TMPE_BIT_MON_SEL];
        // the insert bit is kept as written; it never self-clears
        err_ins_r[ch_idx]          <= wb_dat_i[`TMPE_BIT_ERR_INS];
    end
end

// ==========================================================
// prbs error insertion
// ==========================================================
// the edge is taken on the stored bit, so a second write of one
// while the bit is already one requests nothing
// the gate is sampled with the edge, not held pending: enabling the
// generator later does not release a refused request, which keeps
// the pulse count equal to the number of accepted commands
always @(posedge clk_i) begin
    if (rst_i) begin
        err_ins_prev_r    <= 12'h000;
        prbs_err_insert_o <= 12'h000;
    end else begin
        err_ins_prev_r    <= err_ins_r;
        prbs_err_insert_o <= err_ins_r & ~err_ins_prev_r
                             & prbs_gen_en_i & prbs_rx_en_i;
    end
end

// ==========================================================
// drive monitors, one per channel
// ==========================================================
// each monitor owns its synchronisers, so a pad that floats on an
// unused channel can only raise that channel's alarm
genvar g;
generate
    for (g = 0; g < `TMPE_NCH; g = g + 1) begin : g_mon
        tmpe_drive_mon u_mon (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .int_sel_i (monitor_internal_o[g]),
            .bit_en_i  (tx_bit_en_i[g]),
            .pad_p_i   (line_out_positive_pad_i[g]),
            .pad_n_i   (line_out_negative_pad_i[g]),
            .mon_p_i   (monitor_in_positive_i[g]),
            .mon_n_i   (monitor_in_negative_i[g]),
            .alarm_o   (alarm_w[g])
        );
    end
endgenerate

assign drive_monitor_alarm_o = alarm_w;

// ==========================================================
// interrupts: alarm declarations are sticky events
// ==========================================================
assign alarm_rise = alarm_w & ~alarm_prev_r;

always @* begin
    irq_stat_nxt = irq_stat_r;
    if (rd && !ch_hit && wb_adr_i == `TMPE_ADR_IRQ_STAT)
        irq_stat_nxt = 12'h000;
    // a new event in the clearing cycle survives
    irq_stat_nxt = irq_stat_nxt | alarm_rise;
end

always @(posedge clk_i) begin
    if (rst_i) begin
        alarm_prev_r <= 12'h000;
        irq_stat_r   <= 12'h000;
        irq_mask_r   <= `TMPE_MASK_RST;
        irq_o        <= 1'b0;
    end else begin
        alarm_prev_r <= alarm_w;
        irq_stat_r   <= irq_stat_nxt;
        if (wr && !ch_hit && wb_adr_i == `TMPE_ADR_IRQ_MASK) begin
            if (wb_sel_i[0])
                irq_mask_r[7:0]  <= wb_dat_i[7:0];
            if (wb_sel_i[1])
                irq_mask_r[11:8] <= wb_dat_i[11:8];
        end
        // built from the next status so the line drops in the same
        // cycle that a clearing read takes effect
        irq_o <= |(irq_stat_nxt & irq_mask_r);
    end
end

endmodule // tmpe_tx_ctrl

`default_nettype wire

// File: tb/tmpe_tx_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================
// bus timing and channel 0 control checks
module tmpe_tx_ctrl_checker (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // channel side
    input wire logic [11:0] tx_bit_en_i,
    input wire logic [11:0] prbs_gen_en_i,
    input wire logic [11:0] prbs_rx_en_i,
    input wire logic [11:0] drive_monitor_alarm_o,
    input wire logic [11:0] prbs_err_insert_o,
    input wire logic [11:0] monitor_internal_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_taken_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
    rsv_zero_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[3:0] == 4'h4 && wb_adr_i[7:4] != 4'hF
        |-> wb_dat_o[31:6] == 26'h0 && wb_dat_o[3:0] == 4'h0) else $error("reserved bits set");
    mon_sel_a: assert property (
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h04
        |=> monitor_internal_o[0] == $past(wb_dat_i[5])) else $error("monitor select wrong");
    ins_gate_a: assert property (
        prbs_err_insert_o[0] |-> $past(prbs_gen_en_i[0] && prbs_rx_en_i[0])) else $error("insert while off");
    ins_cause_a: assert property (
        prbs_err_insert_o[0] |-> $past(wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h04 && wb_dat_i[4]))
        else $error("insert without write");
    alarm_edge_a: assert property (
        $changed(drive_monitor_alarm_o[0]) |-> $past(tx_bit_en_i[0])) else $error("alarm moved off period");
endmodule // tmpe_tx_ctrl_checker

bind tmpe_tx_ctrl tmpe_tx_ctrl_checker tmpe_tx_ctrl_checker_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_bit_en_i, .prbs_gen_en_i,
    .prbs_rx_en_i, .drive_monitor_alarm_o, .prbs_err_insert_o, .monitor_internal_o);
`default_nettype wire

// File: tb/tmpe_tx_ctrl_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tmpe_tx_ctrl_tb;
    // ============================================
    // signals
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, irq_o;
    logic [11:0] line_out_positive_pad_i = 12'h000, line_out_negative_pad_i = 12'h000;
    logic [11:0] monitor_in_positive_i = 12'h000, monitor_in_negative_i = 12'h000, tx_bit_en_i = 12'h000;
    logic [11:0] prbs_gen_en_i = 12'h000, prbs_rx_en_i = 12'h000;
    logic [11:0] drive_monitor_alarm_o, prbs_err_insert_o, monitor_internal_o;
    logic [31:0] q[$];
    logic [7:0] v[12];
    int n_errors = 0, comparisons = 0, n_ins = 0;

    tmpe_tx_ctrl tmpe_tx_ctrl_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .line_out_positive_pad_i, .line_out_negative_pad_i,
        .monitor_in_positive_i, .monitor_in_negative_i, .tx_bit_en_i, .prbs_gen_en_i, .prbs_rx_en_i,
        .drive_monitor_alarm_o, .prbs_err_insert_o, .monitor_internal_o, .irq_o);

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // ============================================
    // helpers
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wrap_up;
        $display("counts: %0d errors in %0d comparisons", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ack is read before this edge's updates land, so it is the sampled value
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
            wrap_up();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic bits(input int n);
        repeat (n) begin
            @(posedge clk_i);
            tx_bit_en_i <= 12'hFFF;
            @(posedge clk_i);
            tx_bit_en_i <= 12'h000;
            @(posedge clk_i);
        end
    endtask

    function automatic logic [7:0] ca(input int c);
        return {(c < 6) ? c[3:0] : c[3:0] + 4'h2, 4'h4};
    endfunction

    // read data is judged where it appears; insert pulses are only counted here and judged by later checks
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, q.pop_front());
        n_ins += $countones(prbs_err_insert_o);
    end

    initial begin
        #300000;
        n_errors++;
        wrap_up();
    end

    // ============================================
    // tests
    initial begin
        void'($urandom(24751));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int c = 0; c < 12; c++) rd(ca(c), 32'h0);
        rd(8'h64, 32'h0);
        rd(8'hF4, 32'h0);
        $display("reset values done");
        for (int c = 0; c < 12; c++) begin
            v[c] = 8'($urandom());
            wb(1'b1, ca(c), {24'h0, v[c]});
        end
        for (int c = 0; c < 12; c++) begin
            rd(ca(c), {24'h0, v[c] & 8'h30});
            check(32'(monitor_internal_o[c]), 32'(v[c][5]));
            wb(1'b1, ca(c), 32'h0);
        end
        $display("register map done");
        // k: 0 both on, 1 generator off, 2 receiver off, 3 both on again
        for (int k = 0; k < 4; k++) begin
            prbs_gen_en_i <= {12{k != 1}};
            prbs_rx_en_i <= {12{k != 2}};
            wb(1'b1, 8'h04, 32'h0);
            wb(1'b1, 8'h04, 32'h10);
            repeat (4) @(posedge clk_i);
            check(32'(n_ins), 32'(1 + (k == 3)));
        end
        wb(1'b1, 8'h04, 32'h10);
        repeat (4) @(posedge clk_i);
        check(32'(n_ins), 32'h2);
        wb(1'b1, 8'h04, 32'h0);
        wb(1'b1, ca(11), 32'h10);
        repeat (4) @(posedge clk_i);
        check(32'(n_ins), 32'h3);
        wb(1'b1, ca(11), 32'h0);
        $display("error insert done");
        bits(127);
        check(32'(drive_monitor_alarm_o), 32'h0);
        bits(1);
        check(32'(drive_monitor_alarm_o), 32'hFFF);
        check(32'(irq_o), 32'h0);
        wb(1'b1, 8'hF4, 32'hF01);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h1);
        rd(8'hF4, 32'h001);
        rd(8'hF0, 32'hFFF);
        rd(8'hF0, 32'h0);
        rd(8'hF8, 32'hFFF);
        check(32'(irq_o), 32'h0);
        wb(1'b1, 8'hF4, 32'hF00, 4'h2);
        rd(8'hF4, 32'hF01);
        // channel 0 watches its pads, so its monitor pin must not clear it
        wb(1'b1, 8'h04, 32'h20);
        monitor_in_positive_i <= 12'h001;
        monitor_in_negative_i <= 12'h002;
        repeat (6) @(posedge clk_i);
        bits(1);
        check(32'(drive_monitor_alarm_o), 32'hFFD);
        monitor_in_positive_i <= 12'h000;
        monitor_in_negative_i <= 12'h000;
        line_out_negative_pad_i <= 12'h001;
        repeat (6) @(posedge clk_i);
        bits(1);
        check(32'(drive_monitor_alarm_o), 32'hFFC);
        $display("drive monitor done");
        // a write without byte lane 0 must neither store nor insert
        wb(1'b1, 8'h04, 32'h10, 4'h2);
        rd(8'h04, 32'h20);
        repeat (4) @(posedge clk_i);
        check(32'(n_ins), 32'h3);
        $display("byte lanes done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h04, 32'h0);
        check(32'(monitor_internal_o), 32'h0);
        check(32'(drive_monitor_alarm_o), 32'h0);
        check(32'(irq_o), 32'h0);
        $display("mid-run reset done");
        wrap_up();
    end
endmodule // tmpe_tx_ctrl_tb
`default_nettype wire
